/* File: src/usfl_params.svh */
// Register map, field positions, reset values and counts of the status-flag block
`ifndef USFL_PARAMS_SVH
`define USFL_PARAMS_SVH

// ****************************************
// Register byte addresses
// ****************************************
`define USFL_ADDR_STATUS 12'h004
`define USFL_ADDR_CTRL 12'h00C
`define USFL_ADDR_DATA_LOW 12'h010
`define USFL_ADDR_DATA_HIGH 12'h014

// ****************************************
// Status field positions
// ****************************************
`define USFL_BIT_TX_EMPTY 7
`define USFL_BIT_TX_CMPL 6
`define USFL_BIT_RX_FULL 5
`define USFL_BIT_LINE_QUIET 4

// ****************************************
// Control field positions
// ****************************************
`define USFL_BIT_TXE_IE 7
`define USFL_BIT_CMPL_IE 6
`define USFL_BIT_RXF_IE 5
`define USFL_BIT_IDLE_IE 4
`define USFL_BIT_NINE 3
`define USFL_BIT_SLEEP 2
`define USFL_BIT_BREAK 1
`define USFL_BIT_PREAMBLE 0

// ****************************************
// Reset values and counts
// ****************************************
`define USFL_STATUS_RESET 8'hC0
`define USFL_CTRL_RESET 8'h00
`define USFL_IDLE_BITS_EIGHT 4'h0A
`define USFL_IDLE_BITS_NINE 4'h0B
`define USFL_BIT_TIME_CYCLES 16'h0010

`endif

/* File: src/usfl_pkg.sv */
// Types shared by the status-flag block
package usfl_pkg;
    typedef enum logic [1:0] {
        USFL_SEQ_IDLE,
        USFL_SEQ_ARMED
    } usfl_seq_type;

    typedef logic [7:0] usfl_byte_type;
endpackage : usfl_pkg

/* File: src/usfl_flag_if.sv */
// Interface carrying one flag's set, clear and sequence events
`timescale 1ns/1ps
`default_nettype none
interface usfl_flag_if;
    logic set_ev;
    logic hard_clr;
    logic stat_rd;
    logic data_acc;
    logic flag;
    modport owner (
        input set_ev,
        input hard_clr,
        input stat_rd,
        input data_acc,
        output flag
    );
    modport user (
        output set_ev,
        output hard_clr,
        output stat_rd,
        output data_acc,
        input flag
    );
endinterface : usfl_flag_if
`default_nettype wire

/* File: src/usfl_flag.sv */
// One status flag with read-status-then-data-access clear sequence
`timescale 1ns/1ps
`default_nettype none
module usfl_flag #(
    parameter logic RESET_VAL = 1'b0,
    parameter logic SET_WINS = 1'b1
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    // Flag events
    usfl_flag_if.owner f
);
    import usfl_pkg::*;

    logic flag_r;
    logic flag_nxt;
    usfl_seq_type seq_r;
    usfl_seq_type seq_nxt;
    wire logic seq_clr;
    wire logic any_clr;

    // ****************************************
    // Clear sequence
    // ****************************************
    // Arm only on a status read that saw the flag set
    assign seq_clr = (seq_r == USFL_SEQ_ARMED) && f.data_acc;
    assign any_clr = seq_clr || f.hard_clr;

    always_comb begin
        case (seq_r)
            USFL_SEQ_IDLE: begin
                seq_nxt = (f.stat_rd && flag_r) ? USFL_SEQ_ARMED : USFL_SEQ_IDLE;
            end
            USFL_SEQ_ARMED: begin
                seq_nxt = f.data_acc ? USFL_SEQ_IDLE : USFL_SEQ_ARMED;
            end
            default: begin
                seq_nxt = USFL_SEQ_IDLE;
            end
        endcase
        if (!flag_r && !f.set_ev) begin
            seq_nxt = USFL_SEQ_IDLE;
        end
    end

    // Set-versus-clear priority chosen per flag
    assign flag_nxt = SET_WINS ? (f.set_ev || (flag_r && !any_clr))
                               : (!any_clr && (f.set_ev || flag_r));
    assign f.flag = flag_r;

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            flag_r <= RESET_VAL;
            seq_r <= USFL_SEQ_IDLE;
        end else begin
            flag_r <= flag_nxt;
            seq_r <= seq_nxt;
        end
    end
endmodule : usfl_flag
`default_nettype wire

/* File: src/usfl_idle_det.sv */
// Counts bit times of marking on the receive line
`timescale 1ns/1ps
`default_nettype none
`include "usfl_params.svh"
module usfl_idle_det #(
    parameter logic [15:0] BIT_CYCLES = `USFL_BIT_TIME_CYCLES
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    // Line and mode
    input wire logic i_rx_sync,
    input wire logic i_nine_bit,
    // Detection pulse
    output logic o_idle_seen
);
    logic [15:0] tick_r;
    logic [3:0] ones_r;
    logic hit_r;
    wire logic bit_tick;
    wire logic [3:0] target;

    assign bit_tick = (tick_r == BIT_CYCLES - 16'h0001);
    assign target = i_nine_bit ? `USFL_IDLE_BITS_NINE : `USFL_IDLE_BITS_EIGHT;
    assign o_idle_seen = hit_r;

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            tick_r <= 16'h0000;
            ones_r <= 4'h0;
            hit_r <= 1'b0;
        end else begin
            tick_r <= (!i_rx_sync || bit_tick) ? 16'h0000 : tick_r + 16'h0001;
            hit_r <= 1'b0;
            if (!i_rx_sync) begin
                ones_r <= 4'h0;
            end else if (bit_tick && ones_r != target) begin
                ones_r <= ones_r + 4'h1;
                hit_r <= (ones_r + 4'h1 == target);
            end
        end
    end
endmodule : usfl_idle_det
`default_nettype wire

/* File: src/usfl_top.sv */
// Status-flag logic of a serial transceiver behind an APB slave
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "usfl_params.svh"
module usfl_top #(
    parameter logic [15:0] BIT_CYCLES = `USFL_BIT_TIME_CYCLES
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Transmitter datapath
    input wire logic i_tx_load,
    input wire logic i_tx_busy,
    output logic [8:0] o_tx_data,
    output logic o_tx_queued,
    output logic o_tx_break,
    output logic o_tx_preamble,
    // Receiver datapath
    input wire logic i_rx_xfer,
    input wire logic [8:0] i_rx_data,
    input wire logic i_rx_line,
    input wire logic i_wakeup,
    output logic o_nine_bit,
    // Interrupt requests
    output logic o_irq_tx_empty,
    output logic o_irq_tx_done,
    output logic o_irq_rx_full,
    output logic o_irq_line_quiet
);
    import usfl_pkg::*;

    // ****************************************
    // Declarations
    // ****************************************
    usfl_flag_if empty_if();
    usfl_flag_if cmpl_if();
    usfl_flag_if full_if();
    usfl_flag_if idle_if();

    usfl_byte_type ctrl_r;
    usfl_byte_type ctrl_nxt;
    logic [8:0] tx_hold_r;
    logic [8:0] rx_hold_r;
    logic tx_queued_r;
    logic idle_armed_r;
    logic idle_armed_nxt;
    logic rx_meta_r;
    logic rx_sync_r;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic pslverr_r;
    logic irq_te_r;
    logic irq_cp_r;
    logic irq_rf_r;
    logic irq_il_r;
    logic ready_r;
    wire logic idle_seen;
    wire logic acc;
    wire logic wr;
    wire logic rd;
    wire logic hit_stat;
    wire logic hit_ctrl;
    wire logic hit_dlo;
    wire logic hit_dhi;
    wire logic mapped;
    wire usfl_byte_type status;
    wire logic sleep;
    wire logic idle_set;
    wire logic acc_end;
    wire logic tx_special;

    function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ref_a);
        addr_is = (a == ref_a);
    endfunction : addr_is

    // ****************************************
    // APB decode
    // ****************************************
    // One wait state: read data is registered in the first access cycle
    assign acc = i_psel && i_penable;
    assign acc_end = acc && ready_r;
    assign wr = acc_end && i_pwrite;
    assign rd = acc && !ready_r && !i_pwrite;
    assign hit_stat = addr_is(i_paddr, `USFL_ADDR_STATUS);
    assign hit_ctrl = addr_is(i_paddr, `USFL_ADDR_CTRL);
    assign hit_dlo = addr_is(i_paddr, `USFL_ADDR_DATA_LOW);
    assign hit_dhi = addr_is(i_paddr, `USFL_ADDR_DATA_HIGH);
    assign mapped = hit_stat || hit_ctrl || hit_dlo || hit_dhi;

    // ****************************************
    // Receive line synchroniser
    // ****************************************
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            rx_meta_r <= 1'b1;
            rx_sync_r <= 1'b1;
        end else begin
            rx_meta_r <= i_rx_line;
            rx_sync_r <= rx_meta_r;
        end
    end

    usfl_idle_det #(
        .BIT_CYCLES(BIT_CYCLES)
    ) u_idle_det (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_rx_sync(rx_sync_r),
        .i_nine_bit(ctrl_r[`USFL_BIT_NINE]),
        .o_idle_seen(idle_seen)
    );

    // ****************************************
    // Flag events
    // ****************************************
    // Status write ignored: no path from a status write to any flag
    assign empty_if.set_ev = i_tx_load;
    assign empty_if.hard_clr = 1'b0;
    assign empty_if.stat_rd = rd && hit_stat;
    assign empty_if.data_acc = wr && hit_dlo;

    // Break or preamble bit held: complete stays low as long as it stands
    assign tx_special = ctrl_r[`USFL_BIT_BREAK] || ctrl_r[`USFL_BIT_PREAMBLE];
    // Complete only once empty and nothing is being sent or queued
    assign cmpl_if.set_ev = empty_if.flag && !i_tx_busy && !tx_queued_r
        && !tx_special;
    assign cmpl_if.hard_clr = i_tx_busy || tx_queued_r || tx_special || (wr && hit_ctrl
        && (i_pwdata[`USFL_BIT_BREAK] || i_pwdata[`USFL_BIT_PREAMBLE]));
    assign cmpl_if.stat_rd = rd && hit_stat;
    assign cmpl_if.data_acc = wr && hit_dlo;

    assign full_if.set_ev = i_rx_xfer;
    assign full_if.hard_clr = 1'b0;
    assign full_if.stat_rd = rd && hit_stat;
    assign full_if.data_acc = rd && hit_dlo;

    assign sleep = ctrl_r[`USFL_BIT_SLEEP];
    assign idle_set = idle_seen && idle_armed_r && !sleep;
    assign idle_if.set_ev = idle_set;
    assign idle_if.hard_clr = 1'b0;
    assign idle_if.stat_rd = rd && hit_stat;
    assign idle_if.data_acc = rd && hit_dlo;

    usfl_flag #(.RESET_VAL(1'b1), .SET_WINS(1'b1)) u_empty (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .f(empty_if.owner)
    );
    usfl_flag #(.RESET_VAL(1'b1), .SET_WINS(1'b0)) u_cmpl (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .f(cmpl_if.owner)
    );
    usfl_flag #(.RESET_VAL(1'b0), .SET_WINS(1'b1)) u_full (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .f(full_if.owner)
    );
    usfl_flag #(.RESET_VAL(1'b0), .SET_WINS(1'b1)) u_idle (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .f(idle_if.owner)
    );

    // Rearm after a frame; one idle report per quiet period
    assign idle_armed_nxt = i_rx_xfer ? 1'b1 : (idle_set ? 1'b0 : idle_armed_r);

    // ****************************************
    // Control register
    // ****************************************
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr && hit_ctrl) begin
            ctrl_nxt = i_pwdata[7:0];
        end
        if (i_wakeup) begin
            ctrl_nxt[`USFL_BIT_SLEEP] = 1'b0;
        end
    end

    // ****************************************
    // Read mux
    // ****************************************
    assign status = {empty_if.flag, cmpl_if.flag, full_if.flag, idle_if.flag, 4'h0};

    always_comb begin
        prdata_nxt = 32'h0000_0000;
        if (rd && hit_stat) begin
            prdata_nxt = {24'h00_0000, status};
        end else if (rd && hit_ctrl) begin
            prdata_nxt = {24'h00_0000, ctrl_r};
        end else if (rd && hit_dlo) begin
            prdata_nxt = {24'h00_0000, rx_hold_r[7:0]};
        end else if (rd && hit_dhi) begin
            prdata_nxt = {31'h0000_0000, rx_hold_r[8]};
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_r <= `USFL_CTRL_RESET;
            tx_hold_r <= 9'h000;
            rx_hold_r <= 9'h000;
            tx_queued_r <= 1'b0;
            idle_armed_r <= 1'b1;
        end else begin
            ctrl_r <= ctrl_nxt;
            idle_armed_r <= idle_armed_nxt;
            if (i_rx_xfer) begin
                rx_hold_r <= i_rx_data;
            end
            if (wr && hit_dlo) begin
                tx_hold_r[7:0] <= i_pwdata[7:0];
            end
            if (wr && hit_dhi) begin
                tx_hold_r[8] <= i_pwdata[0];
            end
            tx_queued_r <= (wr && hit_dlo) ? 1'b1 : (i_tx_load ? 1'b0 : tx_queued_r);
        end
    end

    // Outputs registered; requests lag the flags by one cycle
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
            ready_r <= 1'b0;
            irq_te_r <= 1'b0;
            irq_cp_r <= 1'b0;
            irq_rf_r <= 1'b0;
            irq_il_r <= 1'b0;
        end else begin
            prdata_r <= prdata_nxt;
            pslverr_r <= acc && !ready_r && !mapped;
            ready_r <= acc && !ready_r;
            irq_te_r <= empty_if.flag && ctrl_r[`USFL_BIT_TXE_IE];
            irq_cp_r <= cmpl_if.flag && ctrl_r[`USFL_BIT_CMPL_IE];
            irq_rf_r <= full_if.flag && ctrl_r[`USFL_BIT_RXF_IE] && !sleep;
            irq_il_r <= idle_if.flag && ctrl_r[`USFL_BIT_IDLE_IE] && !sleep;
        end
    end

    // Registered answer costs one wait state on every transfer
    assign o_prdata = prdata_r;
    assign o_pready = ready_r;
    assign o_pslverr = pslverr_r;
    assign o_tx_data = tx_hold_r;
    assign o_tx_queued = tx_queued_r;
    assign o_tx_break = ctrl_r[`USFL_BIT_BREAK];
    assign o_tx_preamble = ctrl_r[`USFL_BIT_PREAMBLE];
    assign o_nine_bit = ctrl_r[`USFL_BIT_NINE];
    assign o_irq_tx_empty = irq_te_r;
    assign o_irq_tx_done = irq_cp_r;
    assign o_irq_rx_full = irq_rf_r;
    assign o_irq_line_quiet = irq_il_r;
endmodule : usfl_top
`default_nettype wire

/* File: test/usfl_checker.sv */
// Port-level assertions of the status-flag block
`timescale 1ns/1ps
`default_nettype none
`include "usfl_params.svh"
module usfl_checker #(
    parameter logic [15:0] BIT_CYCLES = 16'h0010
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    // Bus
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    // Datapath
    input wire logic i_tx_load,
    input wire logic i_tx_busy,
    input wire logic o_tx_queued,
    input wire logic i_rx_xfer,
    input wire logic i_rx_line,
    input wire logic i_wakeup,
    // Requests
    input wire logic o_irq_tx_empty,
    input wire logic o_irq_tx_done,
    input wire logic o_irq_rx_full,
    input wire logic o_irq_line_quiet
);
    localparam int QUIET_MIN = 10 * BIT_CYCLES;
    logic [7:0] ctl_r;
    logic [15:0] ones_r;
    wire logic acc = i_psel && i_penable;
    wire logic ctl_wr = acc && o_pready && i_pwrite && i_paddr == `USFL_ADDR_CTRL;
    wire logic sts_rd = acc && o_pready && !i_pwrite && i_paddr == `USFL_ADDR_STATUS;
    // ****************
    // Control shadow, run of marking
    // ****************
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            ctl_r <= 8'h00;
            ones_r <= 16'h0000;
        end else begin
            if (ctl_wr) begin
                ctl_r <= i_pwdata[7:0];
            end
            if (i_wakeup) begin
                ctl_r[2] <= 1'b0;
            end
            if (!i_rx_line) begin
                ones_r <= 16'h0000;
            end else if (ones_r != 16'hFFFF) begin
                ones_r <= ones_r + 16'h0001;
            end
        end
    end
    default clocking dc @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);
    property p_sts; sts_rd |-> o_prdata[31:8] == 24'h00_0000 && o_prdata[3:0] == 4'h0; endproperty
    a_sts: assert property (p_sts) else $error("stray status bits");
    property p_tc_busy; sts_rd && $past(i_tx_busy, 2) |-> !o_prdata[6]; endproperty
    a_tc_busy: assert property (p_tc_busy) else $error("complete while busy");
    property p_done_busy; i_tx_busy |-> ##2 !o_irq_tx_done; endproperty
    a_done_busy: assert property (p_done_busy) else $error("done request while busy");
    property p_done_q; o_tx_queued |-> ##2 !o_irq_tx_done; endproperty
    a_done_q: assert property (p_done_q) else $error("done request while queued");
    property p_te_gate; !$past(ctl_r[7]) |-> !o_irq_tx_empty; endproperty
    a_te_gate: assert property (p_te_gate) else $error("empty request unmasked");
    property p_te_set; i_tx_load ##1 ctl_r[7] |-> ##1 o_irq_tx_empty; endproperty
    a_te_set: assert property (p_te_set) else $error("empty not set by load");
    property p_rf_set; i_rx_xfer ##1 (ctl_r[5] && !ctl_r[2]) |-> ##1 o_irq_rx_full; endproperty
    a_rf_set: assert property (p_rf_set) else $error("full not set by transfer");
    property p_quiet; $rose(o_irq_line_quiet) |-> ones_r >= QUIET_MIN; endproperty
    a_quiet: assert property (p_quiet) else $error("idle seen too early");
    property p_sleep; ctl_r[2] |-> ##1 !(o_irq_line_quiet || o_irq_rx_full); endproperty
    a_sleep: assert property (p_sleep) else $error("receive request in sleep");
    c_load: cover property (i_tx_load);
    c_xfer: cover property (i_rx_xfer);
    c_quiet: cover property ($rose(o_irq_line_quiet));
endmodule : usfl_checker
bind usfl_top usfl_checker #(.BIT_CYCLES(BIT_CYCLES)) usfl_checker_i (
    .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_tx_load(i_tx_load), .i_tx_busy(i_tx_busy),
    .o_tx_queued(o_tx_queued), .i_rx_xfer(i_rx_xfer), .i_rx_line(i_rx_line),
    .i_wakeup(i_wakeup), .o_irq_tx_empty(o_irq_tx_empty), .o_irq_tx_done(o_irq_tx_done),
    .o_irq_rx_full(o_irq_rx_full), .o_irq_line_quiet(o_irq_line_quiet));
`default_nettype wire

/* File: test/usfl_line_model.sv */
// Far-side model: transmit shifter and remote sender on the line
`timescale 1ns/1ps
`default_nettype none
module usfl_line_model #(
    parameter int BITC = 4
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    // Transmit side
    input wire logic i_tx_queued,
    input wire logic i_stall,
    output logic o_tx_load,
    output logic o_tx_busy,
    // Receive side
    output logic o_rx_line,
    output logic o_rx_xfer,
    output logic [8:0] o_rx_data
);
    logic [7:0] cnt_r;
    // ****************
    // Shifter takes the held word, then sends
    // ****************
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            o_tx_load <= 1'b0;
            o_tx_busy <= 1'b0;
            cnt_r <= 8'h00;
        end else begin
            o_tx_load <= i_tx_queued && !i_stall && !o_tx_load && !o_tx_busy;
            if (o_tx_load) begin
                o_tx_busy <= 1'b1;
                cnt_r <= 8'(10 * BITC);
            end else if (cnt_r != 8'h00) begin
                cnt_r <= cnt_r - 8'h01;
            end else begin
                o_tx_busy <= 1'b0;
            end
        end
    end
    // Line marks between frames
    initial begin
        o_rx_line = 1'b1;
        o_rx_xfer = 1'b0;
        o_rx_data = 9'h000;
    end
    // Start bit, data bits from bit 0, stop bit
    task automatic send_frame(input logic [8:0] d, input logic nine);
        o_rx_line <= 1'b0;
        repeat (BITC) @(posedge i_clk_sys);
        for (int i = 0; i < (nine ? 9 : 8); i++) begin
            o_rx_line <= d[i];
            repeat (BITC) @(posedge i_clk_sys);
        end
        o_rx_line <= 1'b1;
        o_rx_data <= d;
        o_rx_xfer <= 1'b1;
        @(posedge i_clk_sys);
        o_rx_xfer <= 1'b0;
    endtask : send_frame
endmodule : usfl_line_model
`default_nettype wire

/* File: test/usfl_top_tb.sv */
// Self-checking bench of the status-flag block
`timescale 1ns/1ps
`default_nettype none
`include "usfl_params.svh"
module usfl_top_tb;
    localparam logic [15:0] BITC = 16'h0004;
    localparam logic [11:0] ST = `USFL_ADDR_STATUS;
    localparam logic [11:0] CT = `USFL_ADDR_CTRL;
    localparam logic [11:0] DL = `USFL_ADDR_DATA_LOW;
    logic clk = 1'b0;
    logic rstn = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic wake = 1'b0;
    logic stall = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic [8:0] tx_data, rx_data;
    logic pready, pslverr, err, tx_load, tx_busy, tx_q, tx_brk, tx_pre, rx_xfer, rx_line, nine;
    logic irq_te, irq_td, irq_rf, irq_lq;
    int fail_count = 0;
    int tests_run = 0;
    int lat [2];
    initial forever #25 clk = ~clk;
    usfl_top #(.BIT_CYCLES(BITC)) usfl_top_i (
        .i_clk_sys(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_tx_load(tx_load), .i_tx_busy(tx_busy), .o_tx_data(tx_data),
        .o_tx_queued(tx_q), .o_tx_break(tx_brk), .o_tx_preamble(tx_pre), .i_rx_xfer(rx_xfer),
        .i_rx_data(rx_data), .i_rx_line(rx_line), .i_wakeup(wake), .o_nine_bit(nine),
        .o_irq_tx_empty(irq_te), .o_irq_tx_done(irq_td), .o_irq_rx_full(irq_rf),
        .o_irq_line_quiet(irq_lq));
    usfl_line_model #(.BITC(4)) usfl_line_model_i (
        .i_clk_sys(clk), .i_rstn(rstn), .i_tx_queued(tx_q), .i_stall(stall),
        .o_tx_load(tx_load), .o_tx_busy(tx_busy), .o_rx_line(rx_line), .o_rx_xfer(rx_xfer),
        .o_rx_data(rx_data));
    // ****************
    // Shared tasks
    // ****************
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Bounded wait of one cycle
    task automatic tick(inout int n);
        @(posedge clk);
        n++;
        if (n > 2000) begin
            fail_count++;
            tally_and_finish();
        end
    endtask : tick
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        pen <= 1'b1;
        do tick(n); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask : apb
    // ****************
    // Scenarios
    // ****************
    task automatic t_regs();
        apb(1'b0, ST, 32'h0000_0000);
        chk(rd, 32'h0000_00C0);
        apb(1'b1, ST, 32'h0000_0000);
        apb(1'b0, ST, 32'h0000_0000);
        chk(rd, 32'h0000_00C0);
        apb(1'b0, 12'h020, 32'h0000_0000);
        chk({31'h0, err}, 32'h0000_0001);
    endtask : t_regs
    task automatic t_tx();
        int n;
        logic [31:0] codes [2] = '{32'h0000_00C1, 32'h0000_00C2};
        n = 0;
        apb(1'b1, CT, 32'h0000_00C0);
        apb(1'b0, ST, 32'h0000_0000);
        apb(1'b1, DL, 32'h0000_005A);
        apb(1'b0, ST, 32'h0000_0000);
        chk(rd & 32'h0000_00C0, 32'h0000_0000);
        chk({22'h0, tx_q, tx_data}, 32'h0000_025A);
        stall <= 1'b0;
        while (tx_busy !== 1'b1) tick(n);
        apb(1'b0, ST, 32'h0000_0000);
        chk(rd & 32'h0000_00C0, 32'h0000_0080);
        while (tx_busy !== 1'b0) tick(n);
        apb(1'b0, ST, 32'h0000_0000);
        chk(rd & 32'h0000_00C0, 32'h0000_00C0);
        chk({31'h0, irq_te}, 32'h0000_0001);
        foreach (codes[i]) begin
            apb(1'b1, CT, codes[i]);
            apb(1'b0, ST, 32'h0000_0000);
            chk(rd & 32'h0000_00C0, 32'h0000_0080);
            chk({30'h0, tx_brk, tx_pre}, codes[i] & 32'h0000_0003);
            apb(1'b1, CT, 32'h0000_00C0);
            apb(1'b0, ST, 32'h0000_0000);
            chk(rd & 32'h0000_00C0, 32'h0000_00C0);
        end
        apb(1'b1, CT, 32'h0000_0000);
        @(posedge clk);
        chk({30'h0, irq_te, irq_td}, 32'h0000_0000);
    endtask : t_tx
    task automatic t_rx();
        int n;
        apb(1'b1, CT, 32'h0000_0030);
        apb(1'b0, ST, 32'h0000_0000);
        apb(1'b0, DL, 32'h0000_0000);
        apb(1'b0, ST, 32'h0000_0000);
        chk(rd & 32'h0000_0010, 32'h0000_0000);
        repeat (15 * BITC) @(posedge clk);
        apb(1'b0, ST, 32'h0000_0000);
        chk(rd & 32'h0000_0010, 32'h0000_0000);
        for (int m = 0; m < 2; m++) begin
            apb(1'b1, CT, 32'h0000_0030 | 32'(m << 3));
            chk({31'h0, nine}, 32'(m));
            usfl_line_model_i.send_frame(m ? 9'h0AA : 9'h055, m[0]);
            n = 0;
            while (irq_lq !== 1'b1) tick(n);
            lat[m] = n;
            apb(1'b0, DL, 32'h0000_0000);
            apb(1'b0, ST, 32'h0000_0000);
            chk(rd & 32'h0000_0030, 32'h0000_0030);
            apb(1'b0, DL, 32'h0000_0000);
            chk(rd, m ? 32'h0000_00AA : 32'h0000_0055);
            apb(1'b0, ST, 32'h0000_0000);
            chk(rd & 32'h0000_0030, 32'h0000_0000);
        end
        chk(32'(lat[1] - lat[0]), 32'(BITC));
        chk({31'h0, lat[0] >= 38 && lat[0] <= 50}, 32'h0000_0001);
    endtask : t_rx
    task automatic t_sleep();
        apb(1'b1, CT, 32'h0000_0014);
        usfl_line_model_i.send_frame(9'h055, 1'b0);
        repeat (15 * BITC) @(posedge clk);
        apb(1'b0, ST, 32'h0000_0000);
        chk(rd & 32'h0000_0010, 32'h0000_0000);
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        apb(1'b0, CT, 32'h0000_0000);
        chk(rd, 32'h0000_0010);
    endtask : t_sleep
    initial begin
        rstn <= 1'b0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_regs();
        t_tx();
        t_rx();
        t_sleep();
        tally_and_finish();
    end
endmodule : usfl_top_tb
`default_nettype wire
